/* srp_host.sv */
// Operation
// - Command byte bits 7:3 carry the target register address.
// - Command bit 2 is 1 for read, 0 for write.
// - Master changes MOSI only on falling serial clock edges.
// - Master ends with chip select and serial clock high; MISO floats (the device model drives the inverse of the last bit instead).
// - Master may end a burst early after the status word.
// - Write sends command then 8 data bits with no clock gap.
// - Writes are 8 bits; 16-bit counter written low byte then high.
// - Master should read back a register after writing it.
// - Master broadcasts 0x01 to sync register; device restarts period.
// - Config bits 5:4 set output rate; same value in every device.
// - Master should burst-read samples after each ready pulse.
// - Every serial word is shifted most significant bit first.
// - Chip select and MOSI low for 64 clocks reset the device.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module srp_host #(
    parameter int RX_WORDS = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic shared_clock_or_ready_pin
);
    typedef struct packed {
        srp_pkg::srp_st_e st;
        logic [7:0] div;
        logic [7:0] bits;
        logic [7:0] total;
        logic [15:0] tx;
        logic [RX_WORDS-1:0][31:0] rx;
        logic [1:0] op;
        logic auto_en;
        logic [4:0] addr;
        logic [7:0] wdata;
        logic [7:0] len;
        logic [7:0] half;
        logic busy;
        logic done;
        logic rdy_flag;
        logic cs_n;
        logic sclk;
        logic mosi;
        logic ap_wr;
        logic [2:0] ap_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } srp_host_s;

    srp_host_s q;
    srp_host_s n;
    logic [1:0] sync_q;
    logic miso_s;
    logic pin_s;
    logic rdy_fell;
    logic start_req;
    logic sel;
    logic [7:0] dbit;

    // ==========================================
    // Pin synchronisation and ready edge
    srp_sync2 #(
        .W(2)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({spi_miso, shared_clock_or_ready_pin}),
        .q(sync_q)
    );

    assign miso_s = sync_q[1];
    assign pin_s = sync_q[0];

    srp_fall_det u_fall (
        .clk(clk),
        .arst_n(arst_n),
        .lvl(pin_s),
        .fell(rdy_fell)
    );

    // ==========================================
    // Register read decode
    function automatic logic [31:0] rd_word(input logic [2:0] idx, input srp_host_s s,
                                            input logic pin);
        logic [31:0] w;
        w = '0;
        unique case (idx)
            srp_pkg::IDX_CTRL: begin
                w[srp_pkg::CTRL_OP_LO +: 2] = s.op;
                w[srp_pkg::CTRL_AUTO] = s.auto_en;
            end
            srp_pkg::IDX_CMD: begin
                w[srp_pkg::CMD_ADDR_LO +: 5] = s.addr;
                w[srp_pkg::CMD_WDATA_LO +: 8] = s.wdata;
                w[srp_pkg::CMD_LEN_LO +: 8] = s.len;
            end
            srp_pkg::IDX_STAT: begin
                w[srp_pkg::STAT_BUSY] = s.busy;
                w[srp_pkg::STAT_RDY] = s.rdy_flag;
                w[srp_pkg::STAT_DONE] = s.done;
                w[srp_pkg::STAT_PIN] = pin;
            end
            srp_pkg::IDX_DIV: begin
                w[7:0] = s.half;
            end
            default: begin
                for (int i = 0; i < RX_WORDS; i++) begin
                    if (idx == 3'(srp_pkg::IDX_RX0 + 3'(i))) begin
                        w = s.rx[i];
                    end
                end
            end
        endcase
        return w;
    endfunction

    // ==========================================
    // Falling serial clock step, next bit out MSB first
    function automatic srp_host_s fall_step(input srp_host_s s);
        srp_host_s r;
        r = s;
        r.st = srp_pkg::SRP_LOW;
        r.sclk = 1'b0;
        r.mosi = s.tx[15];
        r.tx = {s.tx[14:0], 1'b0};
        r.div = s.half;
        return r;
    endfunction

    // ==========================================
    // Next state
    assign sel = hsel && hready && (htrans == srp_pkg::HTRANS_NONSEQ);
    assign dbit = 8'(q.bits - srp_pkg::CMD_BITS);

    always_comb begin
        n = q;
        start_req = 1'b0;
        n.hreadyout = 1'b1;
        n.hresp = srp_pkg::HRESP_OKAY;
        n.ap_wr = 1'b0;
        n.ap_idx = haddr[4:2];
        if (sel && !hwrite) begin
            if ((haddr[31:5] == '0) && (hsize == srp_pkg::HSIZE_WORD)) begin
                n.hrdata = rd_word(haddr[4:2], q, pin_s);
            end else begin
                n.hrdata = '0;
            end
        end
        if (sel && hwrite && (haddr[31:5] == '0) && (hsize == srp_pkg::HSIZE_WORD)) begin
            n.ap_wr = 1'b1;
        end
        if (q.ap_wr) begin
            unique case (q.ap_idx)
                srp_pkg::IDX_CTRL: begin
                    if (q.st == srp_pkg::SRP_IDLE) begin
                        n.op = hwdata[srp_pkg::CTRL_OP_LO +: 2];
                    end
                    n.auto_en = hwdata[srp_pkg::CTRL_AUTO];
                    start_req = hwdata[srp_pkg::CTRL_START];
                end
                srp_pkg::IDX_CMD: begin
                    n.addr = hwdata[srp_pkg::CMD_ADDR_LO +: 5];
                    n.wdata = hwdata[srp_pkg::CMD_WDATA_LO +: 8];
                    n.len = hwdata[srp_pkg::CMD_LEN_LO +: 8];
                end
                srp_pkg::IDX_STAT: begin
                    if (hwdata[srp_pkg::STAT_RDY]) begin
                        n.rdy_flag = 1'b0;
                    end
                    if (hwdata[srp_pkg::STAT_DONE]) begin
                        n.done = 1'b0;
                    end
                end
                srp_pkg::IDX_DIV: begin
                    n.half = hwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (rdy_fell) begin
            n.rdy_flag = 1'b1;
        end
        unique case (q.st)
            srp_pkg::SRP_IDLE: begin
                if (start_req || (q.auto_en && rdy_fell)) begin
                    if (!start_req) begin
                        n.op = srp_pkg::OP_READ;
                    end
                    n.st = srp_pkg::SRP_SETUP;
                    n.busy = 1'b1;
                    n.cs_n = 1'b0;
                    n.div = n.half;
                    n.bits = '0;
                    n.rx = '0;
                    unique case (n.op)
                        srp_pkg::OP_WRITE: begin
                            n.tx = {n.addr, srp_pkg::DIR_WRITE, srp_pkg::CMD_PAD, n.wdata};
                            n.total = srp_pkg::WR_BITS;
                        end
                        srp_pkg::OP_HWRST: begin
                            n.tx = '0;
                            n.total = srp_pkg::HWRST_BITS;
                        end
                        default: begin
                            n.tx = {n.addr, srp_pkg::DIR_READ, srp_pkg::CMD_PAD,
                                    srp_pkg::FILL_ZERO};
                            n.total = 8'(srp_pkg::CMD_BITS + n.len);
                        end
                    endcase
                end
            end
            srp_pkg::SRP_SETUP: begin
                if (q.div != srp_pkg::DIV_LAST) begin
                    n.div = 8'(q.div - srp_pkg::DIV_LAST);
                end else begin
                    n = fall_step(n);
                end
            end
            srp_pkg::SRP_LOW: begin
                if (q.div != srp_pkg::DIV_LAST) begin
                    n.div = 8'(q.div - srp_pkg::DIV_LAST);
                end else begin
                    n.st = srp_pkg::SRP_HIGH;
                    n.sclk = 1'b1;
                    n.div = q.half;
                    n.bits = 8'(q.bits + srp_pkg::DIV_LAST);
                    if ((q.bits >= srp_pkg::CMD_BITS) && (q.op != srp_pkg::OP_WRITE)
                        && (q.op != srp_pkg::OP_HWRST)) begin
                        for (int i = 0; i < RX_WORDS; i++) begin
                            if (dbit[7:5] == 3'(i)) begin
                                n.rx[i] = {q.rx[i][30:0], miso_s};
                            end
                        end
                    end
                end
            end
            srp_pkg::SRP_HIGH: begin
                if (q.div != srp_pkg::DIV_LAST) begin
                    n.div = 8'(q.div - srp_pkg::DIV_LAST);
                end else if (q.bits == q.total) begin
                    n.st = srp_pkg::SRP_DONE;
                    n.cs_n = 1'b1;
                    n.div = q.half;
                end else begin
                    n = fall_step(n);
                end
            end
            srp_pkg::SRP_DONE: begin
                if (q.div != srp_pkg::DIV_LAST) begin
                    n.div = 8'(q.div - srp_pkg::DIV_LAST);
                end else begin
                    n.st = srp_pkg::SRP_IDLE;
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
            end
            default: begin
                n.st = srp_pkg::SRP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.st <= srp_pkg::SRP_IDLE;
            q.half <= srp_pkg::HALF_CYC;
            q.len <= srp_pkg::DEF_LEN;
            q.cs_n <= 1'b1;
            q.sclk <= 1'b1;
            q.hreadyout <= 1'b1;
            q.hresp <= srp_pkg::HRESP_OKAY;
        end else begin
            q <= n;
        end
    end

    // ==========================================
    // Outputs
    assign hreadyout = q.hreadyout;
    assign hresp = q.hresp;
    assign hrdata = q.hrdata;
    assign spi_cs_n = q.cs_n;
    assign spi_sclk = q.sclk;
    assign spi_mosi = q.mosi;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_mosi_on_fall: assert property ($changed(q.mosi) |-> (!q.sclk && $past(q.sclk)))
        else $error("MOSI changed outside a falling serial clock edge");
    chk_msb_first: assert property ($fell(q.sclk) |-> (q.mosi == $past(q.tx[15])))
        else $error("MOSI bit is not the top bit of the shift word");
    chk_idle_pins: assert property (q.cs_n |-> q.sclk)
        else $error("Serial clock low while chip select is high");
    chk_end_last_bit: assert property ($rose(q.cs_n) |-> ($past(q.bits) == $past(q.total)))
        else $error("Chip select rose before the last bit");
    chk_cmd_addr: assert property (($rose(q.busy) && (q.op != srp_pkg::OP_HWRST))
        |-> (q.tx[15:11] == q.addr))
        else $error("Command address field differs from the target");
    chk_cmd_dir: assert property (($rose(q.busy) && (q.op != srp_pkg::OP_HWRST))
        |-> (q.tx[10] == (q.op != srp_pkg::OP_WRITE)))
        else $error("Command direction bit wrong");
    chk_write_len: assert property (($rose(q.busy) && (q.op == srp_pkg::OP_WRITE))
        |-> (q.total == srp_pkg::WR_BITS))
        else $error("Write transfer is not command plus eight bits");
    chk_reset_zero: assert property ((!q.cs_n && (q.op == srp_pkg::OP_HWRST))
        |-> (!q.mosi && (q.total == srp_pkg::HWRST_BITS)))
        else $error("Reset sequence drove MOSI high or wrong length");
    chk_auto_burst: assert property ((q.st == srp_pkg::SRP_IDLE) && q.auto_en && rdy_fell
        && !start_req |=> ((q.st == srp_pkg::SRP_SETUP) && (q.op == srp_pkg::OP_READ)))
        else $error("Ready pulse did not start a read");
    chk_ready_sticky: assert property (rdy_fell |=> q.rdy_flag ##1 (q.rdy_flag || $past(q.ap_wr)))
        else $error("Ready edge lost");
endmodule // srp_host
`default_nettype wire

/* srp_pkg.sv */
`default_nettype none
package srp_pkg;
    // ==========================================
    // Timing
    localparam int CLK_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam logic [7:0] HALF_CYC = 8'((SCLK_PERIOD_NS / 2) / CLK_NS);
    localparam logic [7:0] DIV_LAST = 8'h01;

    // ==========================================
    // Serial command layout
    localparam logic [7:0] CMD_BITS = 8'h08;
    localparam logic [7:0] WR_BITS = 8'h10;
    localparam logic [7:0] HWRST_BITS = 8'h40;
    localparam logic [7:0] DEF_LEN = 8'h18;
    localparam logic [7:0] BURST_CMD = 8'h04;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic [1:0] CMD_PAD = 2'h0;
    localparam logic [7:0] FILL_ZERO = 8'h00;

    // ==========================================
    // Operations
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_HWRST = 2'h2;

    // ==========================================
    // Own register map, word indices
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_CMD = 3'h1;
    localparam logic [2:0] IDX_STAT = 3'h2;
    localparam logic [2:0] IDX_DIV = 3'h3;
    localparam logic [2:0] IDX_RX0 = 3'h4;
    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LO = 1;
    localparam int CTRL_AUTO = 3;
    localparam int CMD_ADDR_LO = 0;
    localparam int CMD_WDATA_LO = 8;
    localparam int CMD_LEN_LO = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RDY = 1;
    localparam int STAT_DONE = 2;
    localparam int STAT_PIN = 3;

    // ==========================================
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {SRP_IDLE, SRP_SETUP, SRP_LOW, SRP_HIGH, SRP_DONE} srp_st_e;
endpackage
`default_nettype wire

/* srp_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module srp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } srp_sync_s;

    srp_sync_s r_q;
    srp_sync_s r_d;

    // ==========================================
    // Two-stage synchroniser
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule // srp_sync2
`default_nettype wire

/* srp_fall_det.sv */
`timescale 1ns/10ps
`default_nettype none
module srp_fall_det (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic lvl,
    output logic fell
);
    typedef struct packed {
        logic prev;
    } srp_fall_s;

    srp_fall_s r_q;
    srp_fall_s r_d;

    // ==========================================
    // High-to-low detection
    always_comb begin
        r_d.prev = lvl;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    assign fell = r_q.prev & ~lvl;
endmodule // srp_fall_det
`default_nettype wire

/* srp_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module srp_dev_model #(
    parameter int PERIOD = 3000,
    parameter logic [7:0] STAT_VAL = 8'h5a
) (
    input wire logic clk,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic [71:0] samples,
    output logic spi_miso,
    output logic pin
);
    // ==========================================
    // Register image and serial state
    logic [7:0] mem [0:7];
    logic [7:0] sh = 8'h00;
    logic [7:0] cmd = 8'h00;
    logic [255:0] st = '0;
    logic sync_go = 1'b0;
    int bitn = 0;
    int zeros = 0;
    int pcnt = 64;

    initial begin
        spi_miso = 1'b0;
        for (int i = 0; i < 8; i++) mem[i] = 8'h00;
    end

    function automatic logic [23:0] regv(input int i);
        if (i < 3) return samples[71-24*i -: 24];
        if (i == 3) return {16'h0000, STAT_VAL};
        return {16'h0000, mem[i]};
    endfunction

    // Sample, status and image registers concatenated from the start address onward
    function automatic logic [255:0] stream_of(input logic [4:0] a);
        logic [255:0] s;
        int p;
        s = '0;
        p = 255;
        for (int i = 0; i < 8; i++) begin
            if (i >= a) begin
                for (int b = ((i < 3) ? 23 : 7); b >= 0; b--) begin
                    s[p] = regv(i) >> b;
                    p--;
                end
            end
        end
        return s;
    endfunction

    // ==========================================
    // Serial port
    always @(negedge spi_cs_n) begin
        bitn = 0;
        zeros = 0;
        cmd = 8'h00;
    end

    always @(posedge spi_sclk) begin
        if (!spi_cs_n) begin
            sh = {sh[6:0], spi_mosi};
            bitn++;
            zeros = spi_mosi ? 0 : zeros + 1;
            if (zeros == 64) begin
                for (int i = 0; i < 8; i++) mem[i] = 8'h00;
            end
            if (bitn == 8) begin
                cmd = sh;
                if (sh[2]) st = stream_of(sh[7:3]);
            end
            if (bitn == 16 && !cmd[2]) begin
                if (cmd[7:3] == 5'h07) sync_go = sh[0];
                else if (cmd[7:3] >= 5'h04 && cmd[7:3] < 5'h07) mem[cmd[7:3]] = sh;
            end
        end
    end

    // Read data leaves on falling edges once the command is in
    always @(negedge spi_sclk) begin
        if (!spi_cs_n && bitn >= 8 && cmd[2]) begin
            spi_miso = st[255];
            st = st << 1;
        end
    end

    // Released line shows the inverse of the last bit
    always @(posedge spi_cs_n) spi_miso = ~spi_miso;

    // ==========================================
    // Output period and shared pin
    always @(posedge clk) begin
        if (sync_go) begin
            pcnt = 0;
            sync_go = 1'b0;
        end else begin
            pcnt = (pcnt + 1) % PERIOD;
        end
    end

    assign pin = mem[6][0] ? clk : (pcnt >= 64);
endmodule // srp_dev_model
`default_nettype wire

/* srp_host_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module srp_host_tb;
    localparam logic [31:0] A_CTRL = 32'(srp_pkg::IDX_CTRL) << 2;
    localparam logic [31:0] A_CMD = 32'(srp_pkg::IDX_CMD) << 2;
    localparam logic [31:0] A_STAT = 32'(srp_pkg::IDX_STAT) << 2;
    localparam logic [31:0] A_DIV = 32'(srp_pkg::IDX_DIV) << 2;
    localparam logic [31:0] A_RX = 32'(srp_pkg::IDX_RX0) << 2;
    logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, pin;
    logic p_cs = 1'b1;
    logic p_mosi = 1'b0;
    logic p_sclk = 1'b1;
    logic [23:0] smp [0:2];
    logic [7:0] shadow [0:7];
    logic [7:0] d;
    integer seed = 32'h1077;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;

    assign hready = hreadyout;

    srp_host srp_host_i (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .shared_clock_or_ready_pin(pin));
    srp_dev_model srp_dev_model_i (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .samples({smp[0], smp[1], smp[2]}), .spi_miso(spi_miso),
        .pin(pin));

    // ==========================================
    // Clock, timeout and wire watch
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            close_out();
        end
        if (arst_n && spi_cs_n) `CHK("sclk_idle", 1'b1, spi_sclk)
        if (!spi_cs_n && !p_cs && spi_mosi !== p_mosi) `CHK("mosi_edge", 2'b10, {p_sclk, spi_sclk})
        p_cs <= spi_cs_n;
        p_mosi <= spi_mosi;
        p_sclk <= spi_sclk;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ==========================================
    // Bus and operation tasks
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= srp_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", srp_pkg::HRESP_OKAY, hresp)
    endtask

    task automatic run_op(input logic [1:0] op, input logic [4:0] a, input logic [7:0] wd,
                          input logic [7:0] len, input logic dbl);
        logic [31:0] q;
        int n;
        ahb(1'b1, A_CMD, (32'(len) << srp_pkg::CMD_LEN_LO) | (32'(wd) << 8) | 32'(a), q);
        ahb(1'b1, A_CTRL, (32'(op) << srp_pkg::CTRL_OP_LO) | 32'h1, q);
        if (dbl) ahb(1'b1, A_CTRL, (32'(srp_pkg::OP_HWRST) << srp_pkg::CTRL_OP_LO) | 32'h1, q);
        n = 0;
        do begin
            ahb(1'b0, A_STAT, 32'h0, q);
            n++;
        end while (q[srp_pkg::STAT_DONE] !== 1'b1 && n < 400);
        `CHK("busy_done", 2'b10, {q[srp_pkg::STAT_DONE], q[srp_pkg::STAT_BUSY]})
        ahb(1'b1, A_STAT, 32'h4, q);
    endtask

    function automatic logic [255:0] exp_stream(input int a);
        logic [255:0] s;
        int p;
        s = '0;
        p = 255;
        for (int i = a; i < 8; i++) begin
            for (int b = ((i < 3) ? 23 : 7); b >= 0; b--) begin
                s[p] = (i < 3) ? smp[i][b] : shadow[i][b];
                p--;
            end
        end
        return s;
    endfunction

    task automatic rd_check(input logic [4:0] a, input int len);
        logic [255:0] s;
        logic [31:0] q, e;
        int n;
        run_op(srp_pkg::OP_READ, a, 8'h00, 8'(len), 1'b0);
        s = exp_stream(a);
        for (int i = 0; i * 32 < len; i++) begin
            n = (len - 32 * i > 32) ? 32 : len - 32 * i;
            e = s[255-32*i -: 32] >> (32 - n);
            ahb(1'b0, A_RX + 32'(4 * i), 32'h0, q);
            `CHK("rx_word", e, q)
        end
    endtask

    task automatic wr_check(input logic [4:0] a, input logic [7:0] wd, input logic dbl);
        logic [31:0] q;
        ahb(1'b1, A_DIV, 32'h3 + 32'($unsigned($random(seed)) % 2), q);
        run_op(srp_pkg::OP_WRITE, a, wd, 8'h08, dbl);
        if (a >= 4 && a < 7) shadow[a] = wd;
        rd_check(a, 8);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = srp_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        for (int i = 0; i < 3; i++) smp[i] = 24'($random(seed));
        for (int i = 0; i < 8; i++) shadow[i] = 8'h00;
        shadow[3] = 8'h5a;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        ahb(1'b0, A_CMD, 32'h0, r);
        `CHK("cmd_reset", 32'h00180000, r)
        ahb(1'b0, A_DIV, 32'h0, r);
        `CHK("div_reset", 32'h00000004, r)
        ahb(1'b0, 32'h00000020, 32'h0, r);
        `CHK("unmapped", 32'h0, r)
        d = 8'($random(seed)) | 8'h01;
        wr_check(5'h04, d, 1'b1);
        wr_check(5'h05, 8'($random(seed)), 1'b0);
        wr_check(5'h03, 8'($random(seed)), 1'b0);
        rd_check(5'h00, 24);
        rd_check(5'h00, 88);
        rd_check(5'h01, 56);
        ahb(1'b1, A_STAT, 32'h2, r);
        wr_check(5'h07, 8'h01, 1'b0);
        ahb(1'b0, A_STAT, 32'h0, r);
        `CHK("ready_fell", 2'b11, {r[srp_pkg::STAT_PIN], r[srp_pkg::STAT_RDY]})
        ahb(1'b1, A_STAT, 32'h2, r);
        ahb(1'b0, A_STAT, 32'h0, r);
        `CHK("ready_clear", 1'b0, r[srp_pkg::STAT_RDY])
        repeat (70) @(posedge clk);
        ahb(1'b0, A_STAT, 32'h0, r);
        `CHK("ready_end", 1'b1, r[srp_pkg::STAT_PIN])
        run_op(srp_pkg::OP_HWRST, 5'h00, 8'h00, 8'h08, 1'b0);
        shadow[4] = 8'h00;
        shadow[5] = 8'h00;
        rd_check(5'h04, 16);
        ahb(1'b1, A_CMD, 32'(srp_pkg::DEF_LEN) << srp_pkg::CMD_LEN_LO, r);
        ahb(1'b1, A_CTRL, 32'h1 << srp_pkg::CTRL_AUTO, r);
        r = 32'h0;
        for (int i = 0; i < 1500 && r[srp_pkg::STAT_DONE] !== 1'b1; i++) begin
            ahb(1'b0, A_STAT, 32'h0, r);
        end
        `CHK("auto_done", 2'b11, {r[srp_pkg::STAT_DONE], r[srp_pkg::STAT_RDY]})
        ahb(1'b0, A_RX, 32'h0, r);
        `CHK("auto_burst", {8'h00, smp[0]}, r)
        ahb(1'b1, A_CTRL, 32'h0, r);
        close_out();
    end
endmodule // srp_host_tb
`default_nettype wire
